// ==== rtl/fio_pkg.sv ====
package fio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Terminal counts
  localparam int NUM_DI = 5;
  localparam int NUM_DO = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter indices
  localparam logic [15:0] IDX_PASSCODE = 16'h0001;
  localparam logic [15:0] IDX_PASS_ENTRY = 16'h0002;
  localparam logic [15:0] IDX_BASIC_LIMIT = 16'h0100;
  localparam logic [15:0] IDX_DO_POLARITY = 16'h0110;
  localparam logic [15:0] IDX_DO_FUNC_SEL = 16'h0111;
  localparam logic [15:0] IDX_DISCONNECT = 16'h0120;
  localparam logic [15:0] IDX_OUT_MON = 16'h0130;
  localparam logic [15:0] IDX_IN_MON = 16'h0131;
  localparam logic [15:0] IDX_LOCK_CFG = 16'h0140;
  localparam logic [15:0] IDX_SELECT = 16'h0150;
  localparam logic [15:0] IDX_FORCED_IN = 16'h0151;
  localparam logic [15:0] IDX_FORCED_OUT = 16'h0152;
  localparam logic [15:0] IDX_PHYS_OUT = 16'h0160;
  localparam logic [15:0] IDX_OUT_MASK = 16'h0161;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] SELECT_RST = 16'h0000;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [31:0] BUS_WORD_RST = 32'h0000_0000;
  localparam logic [2:0] POL_RST = 3'h0;
  localparam logic [5:0] FSEL_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Selection codes and fields
  localparam logic [15:0] SEL_NORMAL = 16'h0000;
  localparam logic [15:0] SEL_IN = 16'h0001;
  localparam logic [15:0] SEL_OUT = 16'h0002;
  localparam logic [15:0] SEL_BOTH = 16'h0003;
  localparam logic [15:0] SEL_BUS = 16'h0004;
  localparam int LOCK_VIEW_BIT = 5;
  localparam int BUS_DO_LSB = 16;
  localparam logic [1:0] FSEL_FUNC = 2'h0;
  localparam logic [1:0] FSEL_FAULT = 2'h1;
  localparam logic [1:0] FSEL_SAFE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int UPDATE_TIME_NS = 125000;
  localparam int UPDATE_CYCLES = UPDATE_TIME_NS / CLK_PERIOD_NS;

endpackage

// ==== rtl/fio_input_sync.sv ====
module fio_input_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // A bit moves only once stages two and three agree
  always_comb begin
    level_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (level_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule

// ==== rtl/fio_passcode.sv ====
module fio_passcode (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_pass,
  input wire logic wr_entry,
  input wire logic [15:0] wdata,
  input wire logic lock_view,
  output logic write_allowed,
  output logic view_restricted,
  output logic unlocked
);

  logic [15:0] pass_reg;
  logic [15:0] pass_next;
  logic unl_reg;
  logic unl_next;
  logic protect;

  assign protect = (pass_reg != fio_pkg::VALUE_RST);

  always_comb begin
    pass_next = pass_reg;
    unl_next = unl_reg;
    if (wr_entry) begin
      unl_next = (wdata == pass_reg); // R20
    end
    if (wr_pass && (!protect || unl_reg)) begin
      pass_next = wdata; // R21
      unl_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pass_reg <= fio_pkg::VALUE_RST;
      unl_reg <= 1'b0;
    end else begin
      pass_reg <= pass_next;
      unl_reg <= unl_next;
    end
  end

  assign write_allowed = !protect || unl_reg; // R18
  assign view_restricted = protect && lock_view && !unl_reg; // R19
  assign unlocked = unl_reg;

endmodule

// ==== rtl/fio_top.sv ====
// Notes on behaviour
// (R1) Selection 0 normal, 1 force inputs, 2 force outputs, 3 both, 4 bus outputs.
// (R2) Input forcing makes functions see forced levels, terminals ignored.
// (R3) Forced-input bit one is high, zero low; bit 0 is first input.
// (R4) Input monitor reports each input level, one bit per input.
// (R5) Under input forcing the input monitor equals the forced-input value.
// (R6) Input forcing lost at reset; selection 0 restores normal inputs.
// (R7) Output forcing drives outputs from forced value, ignoring internal functions.
// (R8) Forced-output bit sets function active; level follows configured polarity.
// (R9) Output monitor reports three terminal levels, first output lowest bit.
// (R10) Keypad output forcing lost at reset; selection 0 restores outputs.
// (R11) Selection 4: bus physical-output word sets terminal levels directly.
// (R12) Bus bits 16..18 map to outputs one..three; one means on.
// (R13) Host writes selection 4, mask 0x00070000, output 0x00060000 to force all.
// (R14) Bus forcing cleared at reset or by selection 0.
// (R15) Disconnect setting blanks outputs by bitmask while bus non-operational.
// (R16) Disconnect setting 7 releases all three outputs while non-operational.
// (R17) Safe-state function active only when both torque-off inputs are low.
// (R18) With a passcode set, only unlocked operators change parameters.
// (R19) Lock bit 5 plus passcode hides non-basic parameters from view and change.
// (R20) Operator enters current passcode before writing a new one.
// (R21) Writing 0 to passcode after entry cancels protection.
// (R22) Selection changes apply at next update tick, outputs stay registered.
module fio_top #(
  parameter int NUM_DI = fio_pkg::NUM_DI,
  parameter int UPDATE_CYCLES = fio_pkg::UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] param_index,
  input wire logic [31:0] param_wdata,
  input wire logic param_wr,
  input wire logic param_rd,
  output logic [31:0] param_rdata,
  output logic param_ack,
  output logic param_denied,
  input wire logic [NUM_DI-1:0] di_pin,
  output logic [NUM_DI-1:0] di_seen,
  input wire logic [2:0] do_func,
  input wire logic fault_active,
  input wire logic bus_operational,
  input wire logic torque_off_input_a,
  input wire logic torque_off_input_b,
  output logic safe_state_output,
  output logic fault_output,
  output logic [2:0] do_pin_out,
  output logic [2:0] do_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_basic(input logic [15:0] idx);
    is_basic = (idx < fio_pkg::IDX_BASIC_LIMIT);
  endfunction

  function automatic logic forces_in(input logic [15:0] sel);
    forces_in = (sel == fio_pkg::SEL_IN) || (sel == fio_pkg::SEL_BOTH); // R1
  endfunction

  function automatic logic forces_out(input logic [15:0] sel);
    forces_out = (sel == fio_pkg::SEL_OUT) || (sel == fio_pkg::SEL_BOTH); // R1
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins

  logic [NUM_DI-1:0] di_sync;
  logic [1:0] sto_sync;

  fio_input_sync #(.W(NUM_DI)) u_di_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(di_pin),
    .level_out(di_sync)
  );

  fio_input_sync #(.W(2)) u_sto_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    // Stored inverted so cleared stages match powered pins, no false safe state
    .pin_in({~torque_off_input_b, ~torque_off_input_a}),
    .level_out(sto_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Parameter access

  logic wr_ok;
  logic rd_ok;
  logic write_allowed;
  logic view_restricted;
  logic [15:0] lock_reg;
  logic [15:0] lock_next;

  // Passcode entry stays open so a locked operator can still log in
  always_comb begin
    wr_ok = 1'b1;
    if (param_index != fio_pkg::IDX_PASS_ENTRY) begin
      if (!write_allowed) begin
        wr_ok = 1'b0; // R18
      end
      if (view_restricted && !is_basic(param_index)) begin
        wr_ok = 1'b0; // R19
      end
    end
    rd_ok = !(view_restricted && !is_basic(param_index)); // R19
  end

  fio_passcode u_passcode (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_pass(param_wr && (param_index == fio_pkg::IDX_PASSCODE) && !view_restricted),
    .wr_entry(param_wr && (param_index == fio_pkg::IDX_PASS_ENTRY)),
    .wdata(param_wdata[15:0]),
    .lock_view(lock_reg[fio_pkg::LOCK_VIEW_BIT]),
    .write_allowed(write_allowed),
    .view_restricted(view_restricted),
    .unlocked()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [15:0] sel_reg;
  logic [15:0] sel_next;
  logic [15:0] fin_reg;
  logic [15:0] fin_next;
  logic [15:0] fout_reg;
  logic [15:0] fout_next;
  logic [15:0] disc_reg;
  logic [15:0] disc_next;
  logic [31:0] phys_reg;
  logic [31:0] phys_next;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [2:0] pol_reg;
  logic [2:0] pol_next;
  logic [5:0] fsel_reg;
  logic [5:0] fsel_next;
  logic wr_go;

  assign wr_go = param_wr && wr_ok;

  always_comb begin
    sel_next = sel_reg;
    fin_next = fin_reg;
    fout_next = fout_reg;
    disc_next = disc_reg;
    phys_next = phys_reg;
    mask_next = mask_reg;
    pol_next = pol_reg;
    fsel_next = fsel_reg;
    lock_next = lock_reg;
    if (wr_go) begin
      unique case (param_index)
        fio_pkg::IDX_SELECT: sel_next = param_wdata[15:0]; // R1
        fio_pkg::IDX_FORCED_IN: fin_next = param_wdata[15:0];
        fio_pkg::IDX_FORCED_OUT: fout_next = param_wdata[15:0];
        fio_pkg::IDX_DISCONNECT: disc_next = param_wdata[15:0];
        fio_pkg::IDX_PHYS_OUT: phys_next = param_wdata;
        fio_pkg::IDX_OUT_MASK: mask_next = param_wdata;
        fio_pkg::IDX_DO_POLARITY: pol_next = param_wdata[2:0];
        fio_pkg::IDX_DO_FUNC_SEL: fsel_next = param_wdata[5:0];
        fio_pkg::IDX_LOCK_CFG: lock_next = param_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Nothing retained across reset, so every override starts cleared
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_reg <= fio_pkg::SELECT_RST; // R6 R10 R14
      fin_reg <= fio_pkg::VALUE_RST;
      fout_reg <= fio_pkg::VALUE_RST;
      disc_reg <= fio_pkg::VALUE_RST;
      phys_reg <= fio_pkg::BUS_WORD_RST;
      mask_reg <= fio_pkg::BUS_WORD_RST;
      pol_reg <= fio_pkg::POL_RST;
      fsel_reg <= fio_pkg::FSEL_RST;
      lock_reg <= fio_pkg::VALUE_RST;
    end else begin
      sel_reg <= sel_next;
      fin_reg <= fin_next;
      fout_reg <= fout_next;
      disc_reg <= disc_next;
      phys_reg <= phys_next;
      mask_reg <= mask_next;
      pol_reg <= pol_next;
      fsel_reg <= fsel_next;
      lock_reg <= lock_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update tick

  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_cnt_next;
  logic tick;
  logic [15:0] sel_act_reg;
  logic [15:0] sel_act_next;

  always_comb begin
    tick = (tick_cnt_reg == 16'(UPDATE_CYCLES - 1));
    tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    sel_act_next = tick ? sel_reg : sel_act_reg; // R22
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= 16'h0000;
      sel_act_reg <= fio_pkg::SELECT_RST;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      sel_act_reg <= sel_act_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input and output paths

  logic [NUM_DI-1:0] di_reg;
  logic [NUM_DI-1:0] di_next;
  logic [2:0] lvl_reg;
  logic [2:0] lvl_next;
  logic [2:0] oen_reg;
  logic [2:0] oen_next;
  logic safe_reg;
  logic safe_next;
  logic safe_now;
  logic [2:0] act;

  assign safe_now = (sto_sync == 2'h3); // R17

  always_comb begin
    safe_next = safe_now;
    di_next = forces_in(sel_act_reg) ? fin_reg[NUM_DI-1:0] : di_sync; // R2 R3
    for (int i = 0; i < 3; i++) begin
      unique case (fsel_reg[2*i +: 2])
        fio_pkg::FSEL_FAULT: act[i] = fault_active;
        fio_pkg::FSEL_SAFE: act[i] = safe_now;
        default: act[i] = do_func[i];
      endcase
      if (forces_out(sel_act_reg)) begin
        act[i] = fout_reg[i]; // R7
      end
      // Polarity bit set means the terminal is active low
      lvl_next[i] = act[i] ^ pol_reg[i]; // R8
      if ((sel_act_reg == fio_pkg::SEL_BUS) && mask_reg[fio_pkg::BUS_DO_LSB + i]) begin
        lvl_next[i] = phys_reg[fio_pkg::BUS_DO_LSB + i]; // R11 R12
      end
      oen_next[i] = 1'b0;
      if (!bus_operational && disc_reg[i]) begin
        lvl_next[i] = 1'b0; // R15 R16
        oen_next[i] = 1'b1;
      end
    end
  end

  // Registered drive keeps a source switch from glitching the pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      di_reg <= '0;
      lvl_reg <= 3'h0;
      oen_reg <= 3'h7;
      safe_reg <= 1'b0;
    end else begin
      di_reg <= di_next;
      lvl_reg <= lvl_next; // R22
      oen_reg <= oen_next;
      safe_reg <= safe_next;
    end
  end

  assign di_seen = di_reg;
  assign do_pin_out = lvl_reg;
  assign do_pin_oe_n = oen_reg;
  assign safe_state_output = safe_reg; // R17
  assign fault_output = fault_active;

  ////////////////////////////////////////////////////////////////////////////
  // Read answer

  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic denied_reg;

  always_comb begin
    rdata_next = rdata_reg;
    if (param_rd && rd_ok) begin
      unique case (param_index)
        fio_pkg::IDX_SELECT: rdata_next = {16'h0000, sel_reg};
        fio_pkg::IDX_FORCED_IN: rdata_next = {16'h0000, fin_reg};
        fio_pkg::IDX_FORCED_OUT: rdata_next = {16'h0000, fout_reg};
        fio_pkg::IDX_DISCONNECT: rdata_next = {16'h0000, disc_reg};
        fio_pkg::IDX_PHYS_OUT: rdata_next = phys_reg;
        fio_pkg::IDX_OUT_MASK: rdata_next = mask_reg;
        fio_pkg::IDX_DO_POLARITY: rdata_next = {29'h0000_0000, pol_reg};
        fio_pkg::IDX_DO_FUNC_SEL: rdata_next = {26'h000_0000, fsel_reg};
        fio_pkg::IDX_LOCK_CFG: rdata_next = {16'h0000, lock_reg};
        fio_pkg::IDX_IN_MON: rdata_next = 32'(di_reg); // R4 R5
        fio_pkg::IDX_OUT_MON: rdata_next = {29'h0000_0000, lvl_reg}; // R9
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      denied_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= param_rd || param_wr;
      denied_reg <= (param_rd && !rd_ok) || (param_wr && !wr_ok);
    end
  end

  assign param_rdata = rdata_reg;
  assign param_ack = ack_reg;
  assign param_denied = denied_reg;

endmodule

// ==== tb/fio_assertions.sv ====
module fio_checker #(
  parameter int NUM_DI = 5,
  parameter int UPDATE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [31:0] param_rdata,
  input wire logic param_ack,
  input wire logic param_denied,
  input wire logic bus_operational,
  input wire logic torque_off_input_a,
  input wire logic torque_off_input_b,
  input wire logic safe_state_output,
  input wire logic [2:0] do_pin_out,
  input wire logic [2:0] do_pin_oe_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  property p_ack;
    (param_wr || param_rd) |=> param_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_no_ack;
    !(param_wr || param_rd) |=> !param_ack;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack without request");
  property p_deny;
    param_denied |-> param_ack;
  endproperty
  a_deny: assert property (p_deny) else $error("denied without ack");
  property p_rdata;
    (!$past(param_rd) || param_denied) |-> $stable(param_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_blank;
    (do_pin_oe_n & do_pin_out) == 3'b000;
  endproperty
  a_blank: assert property (p_blank) else $error("released output not low");
  // Three samples allow for the output register stage
  property p_drive;
    bus_operational [*3] |-> do_pin_oe_n == 3'b000;
  endproperty
  a_drive: assert property (p_drive) else $error("output released while operational");
  // Eight cycles cover the input synchroniser
  property p_safe_on;
    (!torque_off_input_a && !torque_off_input_b) [*8] |-> safe_state_output;
  endproperty
  a_safe_on: assert property (p_safe_on) else $error("safe state missing");
  property p_safe_off;
    (torque_off_input_a || torque_off_input_b) [*8] |-> !safe_state_output;
  endproperty
  a_safe_off: assert property (p_safe_off) else $error("safe state with one input");
  c_denied: cover property (param_denied);
  c_blank: cover property (do_pin_oe_n == 3'b111);
  c_safe: cover property (safe_state_output);
endmodule

bind fio_top fio_checker #(.NUM_DI(NUM_DI), .UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (
  .clk,
  .sys_rst,
  .param_wr,
  .param_rd,
  .param_rdata,
  .param_ack,
  .param_denied,
  .bus_operational,
  .torque_off_input_a,
  .torque_off_input_b,
  .safe_state_output,
  .do_pin_out,
  .do_pin_oe_n
);

// ==== tb/fio_host_model.sv ====
module fio_host_model (
  input wire logic clk,
  output logic [15:0] param_index,
  output logic [31:0] param_wdata,
  output logic param_wr,
  output logic param_rd,
  input wire logic [31:0] param_rdata,
  input wire logic param_ack,
  input wire logic param_denied
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    param_index = 16'h0000;
    param_wdata = 32'h0000_0000;
    param_wr = 1'b0;
    param_rd = 1'b0;
  end
  ////////////////////////////////////////
  // One-cycle request, answer taken one cycle later
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    @(posedge clk);
    param_wr <= w;
    param_rd <= !w;
    param_index <= i;
    param_wdata <= d;
    @(posedge clk);
    param_wr <= 1'b0;
    param_rd <= 1'b0;
    // Stale lines must not look valid
    param_index <= ~i;
    param_wdata <= ~d;
    #1;
    q = param_rdata;
    r = {param_ack, param_denied};
  endtask
endmodule

// ==== tb/forced_io_override_tb_top.sv ====
module forced_io_override_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UPD = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] param_index;
  logic [31:0] param_wdata, param_rdata, q;
  logic param_wr, param_rd, param_ack, param_denied;
  logic [4:0] di_pin = 5'h00;
  logic [4:0] di_seen;
  logic [2:0] do_func = 3'h0;
  logic fault_active = 1'b0;
  logic bus_operational = 1'b1;
  logic torque_off_input_a = 1'b1;
  logic torque_off_input_b = 1'b1;
  logic safe_state_output, fault_output;
  logic [2:0] do_pin_out, do_pin_oe_n;
  logic [1:0] r;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  fio_top #(.UPDATE_CYCLES(UPD)) u_dut (.clk, .sys_rst, .param_index, .param_wdata,
    .param_wr, .param_rd, .param_rdata, .param_ack, .param_denied, .di_pin, .di_seen,
    .do_func, .fault_active, .bus_operational, .torque_off_input_a, .torque_off_input_b,
    .safe_state_output, .fault_output, .do_pin_out, .do_pin_oe_n);
  fio_host_model u_host (.clk, .param_index, .param_wdata, .param_wr, .param_rd,
    .param_rdata, .param_ack, .param_denied);

  always #50 clk = ~clk;
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic e);
    u_host.acc(1'b1, i, d, q, r);
    chk(32'(r), 32'({1'b1, e}));
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e, input logic ed);
    u_host.acc(1'b0, i, 32'h0000_0000, q, r);
    chk(32'(r), 32'({1'b1, ed}));
    if (!ed) begin
      chk(q, e);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    settle(3);
    chk(32'({do_pin_oe_n, do_pin_out}), 32'({3'h0, do_func}));
    chk(32'(safe_state_output), 32'h0000_0000);
    rd(fio_pkg::IDX_SELECT, 32'(fio_pkg::SELECT_RST), 1'b0);
    rd(fio_pkg::IDX_OUT_MASK, fio_pkg::BUS_WORD_RST, 1'b0);
    wr(fio_pkg::IDX_OUT_MON, 32'h0000_0007, 1'b0);
    rd(fio_pkg::IDX_OUT_MON, 32'(do_func), 1'b0);
    rd(16'h0fff, 32'h0000_0000, 1'b0);
  endtask
  task automatic t_fin();
    @(posedge clk);
    di_pin <= 5'h01;
    wr(fio_pkg::IDX_FORCED_IN, 32'h0000_001e, 1'b0);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_IN), 1'b0);
    settle(12);
    chk(32'(di_seen), 32'h0000_001e);
    rd(fio_pkg::IDX_IN_MON, 32'h0000_001e, 1'b0);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_NORMAL), 1'b0);
    settle(12);
    chk(32'(di_seen), 32'h0000_0001);
    rd(fio_pkg::IDX_IN_MON, 32'h0000_0001, 1'b0);
  endtask
  task automatic t_fout();
    @(posedge clk);
    do_func <= 3'h2;
    wr(fio_pkg::IDX_FORCED_OUT, 32'h0000_0006, 1'b0);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_OUT), 1'b0);
    settle(12);
    chk(32'(do_pin_out), 32'h0000_0006);
    rd(fio_pkg::IDX_OUT_MON, 32'h0000_0006, 1'b0);
    wr(fio_pkg::IDX_DO_POLARITY, 32'h0000_0007, 1'b0);
    settle(3);
    rd(fio_pkg::IDX_OUT_MON, 32'h0000_0001, 1'b0);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_BOTH), 1'b0);
    settle(12);
    chk(32'(do_pin_out), 32'h0000_0001);
    wr(fio_pkg::IDX_DO_POLARITY, 32'h0000_0000, 1'b0);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_NORMAL), 1'b0);
    settle(12);
    chk(32'(do_pin_out), 32'h0000_0002);
  endtask
  task automatic t_disc();
    int ks[3] = '{5, 7, 0};
    @(posedge clk);
    do_func <= 3'h7;
    bus_operational <= 1'b0;
    foreach (ks[k]) begin
      wr(fio_pkg::IDX_DISCONNECT, 32'(ks[k]), 1'b0);
      settle(3);
      chk(32'({do_pin_oe_n, do_pin_out}), 32'({ks[k][2:0], ~ks[k][2:0]}));
    end
    @(posedge clk);
    bus_operational <= 1'b1;
  endtask
  task automatic t_safe();
    @(posedge clk);
    torque_off_input_a <= 1'b0;
    settle(8);
    chk(32'(safe_state_output), 32'h0000_0000);
    @(posedge clk);
    torque_off_input_b <= 1'b0;
    settle(8);
    chk(32'(safe_state_output), 32'h0000_0001);
    wr(fio_pkg::IDX_DO_FUNC_SEL, 32'h0000_0018, 1'b0);
    settle(3);
    chk(32'(do_pin_out), 32'h0000_0003);
    @(posedge clk);
    torque_off_input_a <= 1'b1;
    torque_off_input_b <= 1'b1;
    fault_active <= 1'b1;
    settle(8);
    chk(32'({safe_state_output, fault_output}), 32'h0000_0001);
    chk(32'(do_pin_out), 32'h0000_0005);
    wr(fio_pkg::IDX_DO_FUNC_SEL, 32'h0000_0000, 1'b0);
  endtask
  task automatic t_bus();
    wr(fio_pkg::IDX_OUT_MASK, 32'h0007_0000, 1'b0);
    wr(fio_pkg::IDX_PHYS_OUT, 32'h0006_0000, 1'b0);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_BUS), 1'b0);
    settle(12);
    chk(32'(do_pin_out), 32'h0000_0006);
    wr(fio_pkg::IDX_PHYS_OUT, 32'h0001_0000, 1'b0);
    settle(3);
    rd(fio_pkg::IDX_OUT_MON, 32'h0000_0001, 1'b0);
    wr(fio_pkg::IDX_OUT_MASK, 32'h0001_0000, 1'b0);
    settle(3);
    chk(32'(do_pin_out), 32'h0000_0007);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_NORMAL), 1'b0);
    settle(12);
    chk(32'(do_pin_out), 32'(do_func));
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_BUS), 1'b0);
    settle(12);
  endtask
  task automatic t_pass();
    wr(fio_pkg::IDX_LOCK_CFG, 32'h0000_0020, 1'b0);
    wr(fio_pkg::IDX_PASSCODE, 32'h0000_1234, 1'b0);
    wr(fio_pkg::IDX_PASSCODE, 32'h0000_5555, 1'b1);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_IN), 1'b1);
    rd(fio_pkg::IDX_SELECT, 32'h0000_0000, 1'b1);
    rd(16'h0050, 32'h0000_0000, 1'b0);
    wr(fio_pkg::IDX_PASS_ENTRY, 32'h0000_1111, 1'b0);
    wr(fio_pkg::IDX_FORCED_IN, 32'h0000_0000, 1'b1);
    wr(fio_pkg::IDX_PASS_ENTRY, 32'h0000_1234, 1'b0);
    wr(fio_pkg::IDX_PASSCODE, 32'h0000_0000, 1'b0);
    wr(fio_pkg::IDX_SELECT, 32'(fio_pkg::SEL_NORMAL), 1'b0);
    rd(fio_pkg::IDX_SELECT, 32'h0000_0000, 1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    t_reset();
    t_fin();
    t_fout();
    t_disc();
    t_safe();
    t_bus();
    t_reset();
    t_pass();
    print_verdict();
  end
endmodule
